/* File: logic/icc_config_reg.sv */
// Configuration register, input word checking and channel output control.
// Assumes serial pins are asynchronous to clk and run well below clk/4;
// data source, FIFO flags and neighbouring register fields share clk.
`timescale 1ns/1ps
// What this block does
// - Bit 15 set runs the input pattern-checker test.
// - Pattern test forces converter outputs off regardless of transmit enables.
// - Bit 12 set clears interface alarms after 64 good samples.
// - Without auto-clear, alarms stay until software clears them.
// - Bit 11 selects parity: 0 even, 1 odd.
// - Bit 10 set checks each word against the parity input pair.
// - Bit 9 set checks parity carried on the framing signal.
// - Bit 8 set gives quad mode; cleared with pairing 11 gives B,C only.
// - Bits 7 to 4 invert output data of channels A to D.
// - Bit 3 set enables the pointers-two-apart FIFO alarm.
// - Bit 2 set enables the pointers-one-apart FIFO alarm.
// - Bit 1 set enables the pointer collision FIFO alarm.
// - Bits 14, 13 and 0 are reserved, reset 0, kept 0.
// - Register at address 0x01, reset value 0x050E.
// - Collision alarm shuts outputs off when enabled and not masked.
module icc_config_reg #(
  parameter int DATA_W = 16,
  parameter logic [16*8-1:0] PATTERN = 128'h7A7A_B6B6_EAEA_4545_1A1A_1616_AAAA_C6C6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial configuration pins
  input wire logic sif_clk,
  input wire logic sif_enable_n,
  input wire logic sif_data_in,
  output logic sif_data_out,
  output logic sif_data_oe,
  // Checked input bus
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic parity_input_pair,
  input wire logic frame_in,
  // FIFO pointer distance flags
  input wire logic fifo_gap_two,
  input wire logic fifo_gap_one,
  input wire logic fifo_collision,
  // Fields of neighbouring registers and transmit enables
  input wire logic [1:0] channel_pairing_register,
  input wire logic collision_shutdown_enable,
  input wire logic collision_alarm_masked,
  input wire logic output_gone_masked,
  input wire logic tx_enable_pin,
  input wire logic sif_tx_enable,
  // Channel data path
  input wire logic [DATA_W-1:0] ch_a_in,
  input wire logic [DATA_W-1:0] ch_b_in,
  input wire logic [DATA_W-1:0] ch_c_in,
  input wire logic [DATA_W-1:0] ch_d_in,
  output logic [DATA_W-1:0] ch_a_out,
  output logic [DATA_W-1:0] ch_b_out,
  output logic [DATA_W-1:0] ch_c_out,
  output logic [DATA_W-1:0] ch_d_out,
  // Status
  output logic [3:0] channel_active,
  output logic outputs_enabled,
  output logic [5:0] alarms,
  output logic [15:0] config_value
);
  if (DATA_W != 16) $error("icc_config_reg supports 16-bit words only");

  typedef struct packed {
    logic [1:0] clk_sy;
    logic [1:0] en_sy;
    logic [1:0] din_sy;
    logic [1:0] txen_sy;
    logic clk_prev;
    logic [4:0] bit_cnt;
    logic [23:0] shift;
    logic [15:0] rd_shift;
    logic sdo;
    logic sdo_oe;
    logic [15:0] cfg;
    logic [5:0] alarm;
    logic [5:0] good_cnt;
    logic [2:0] pat_idx;
    logic shutdown;
    logic out_en;
    logic [3:0] active;
    logic [DATA_W-1:0] a_out;
    logic [DATA_W-1:0] b_out;
    logic [DATA_W-1:0] c_out;
    logic [DATA_W-1:0] d_out;
  } icc_state_t;

  icc_state_t st;
  icc_state_t next_st;

  // Register read decode, unmapped addresses read zero
  function automatic logic [15:0] read_value(input logic [6:0] addr, input icc_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    if (addr == icc_pkg::ADDR_CONFIG)
      v = s.cfg;
    else if (addr == icc_pkg::ADDR_ALARM)
      v = {10'h000, s.alarm};
    return v;
  endfunction

  // Parity error for one carried bit against the odd/even select
  function automatic logic parity_bad(input logic [DATA_W-1:0] d, input logic p, input logic odd);
    return (^{d, p}) != odd;
  endfunction

  logic word_err;
  logic frame_err;
  logic pat_err;
  logic good;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_done;
  logic is_read;
  logic [6:0] addr;
  logic [5:0] alarm_set;
  logic [15:0] wdata;
  logic dual;

  // Next state
  always_comb
  begin
    next_st = st;
    // Synchronisers: stage 0 feeds only stage 1
    next_st.clk_sy = {st.clk_sy[0], sif_clk};
    next_st.en_sy = {st.en_sy[0], sif_enable_n};
    next_st.din_sy = {st.din_sy[0], sif_data_in};
    next_st.txen_sy = {st.txen_sy[0], tx_enable_pin};
    next_st.clk_prev = st.clk_sy[1];
    sclk_rise = st.clk_sy[1] && !st.clk_prev;
    sclk_fall = !st.clk_sy[1] && st.clk_prev;
    frame_done = 1'b0;

    // Serial frame: R/W, 7-bit address, 16 data bits, MSB first on rising edges
    if (st.en_sy[1])
    begin
      next_st.bit_cnt = 5'h00;
      next_st.sdo_oe = 1'b0;
    end
    else
    begin
      if (sclk_rise && st.bit_cnt != 5'(icc_pkg::SIF_FRAME_BITS))
      begin
        next_st.shift = {st.shift[22:0], st.din_sy[1]};
        next_st.bit_cnt = st.bit_cnt + 5'h01;
      end
      if (st.bit_cnt == 5'(icc_pkg::SIF_HEADER_BITS)
          && st.shift[icc_pkg::SIF_HEADER_BITS - 1] && !st.sdo_oe)
      begin
        next_st.rd_shift = read_value({st.shift[6:0]}, st);
        next_st.sdo_oe = 1'b1;
      end
      // Read data leaves on falling edges so the host samples it on rising ones
      if (sclk_fall && st.sdo_oe)
      begin
        next_st.sdo = st.rd_shift[15];
        next_st.rd_shift = {st.rd_shift[14:0], 1'b0};
      end
      frame_done = sclk_rise && st.bit_cnt == 5'(icc_pkg::SIF_FRAME_BITS - 1);
    end
    // Frame fields include the bit shifted in on the final rise
    is_read = next_st.shift[icc_pkg::SIF_RW_BIT];
    addr = next_st.shift[22:16];
    wdata = next_st.shift[15:0];

    // Input word checks
    word_err = sample_valid && st.cfg[icc_pkg::BIT_WORD_PARITY]
      && parity_bad(sample_data, parity_input_pair, st.cfg[icc_pkg::BIT_ODD_PARITY]);
    frame_err = sample_valid && st.cfg[icc_pkg::BIT_FRAME_PARITY]
      && parity_bad(sample_data, frame_in, st.cfg[icc_pkg::BIT_ODD_PARITY]);
    pat_err = sample_valid && st.cfg[icc_pkg::BIT_IOTEST]
      && sample_data != PATTERN[(7 - (frame_in ? 3'h0 : st.pat_idx))*16 +: 16];
    good = sample_valid && !word_err && !frame_err && !pat_err;
    if (sample_valid)
      next_st.pat_idx = frame_in ? 3'h1 : st.pat_idx + 3'h1;

    alarm_set = 6'h00;
    alarm_set[icc_pkg::ALM_WORD_PARITY] = word_err;
    alarm_set[icc_pkg::ALM_FRAME_PARITY] = frame_err;
    alarm_set[icc_pkg::ALM_PATTERN] = pat_err;
    alarm_set[icc_pkg::ALM_GAP_TWO] = fifo_gap_two && st.cfg[icc_pkg::BIT_GAP_TWO];
    alarm_set[icc_pkg::ALM_GAP_ONE] = fifo_gap_one && st.cfg[icc_pkg::BIT_GAP_ONE];
    alarm_set[icc_pkg::ALM_COLLISION] = fifo_collision && st.cfg[icc_pkg::BIT_COLLISION];

    // Good-sample run counter; any bad sample restarts it
    if (!sample_valid)
      next_st.good_cnt = st.good_cnt;
    else if (!good)
      next_st.good_cnt = 6'h00;
    else
      next_st.good_cnt = st.good_cnt + 6'h01;

    // Sticky alarms: software writes 0 to clear; new events win over clears
    next_st.alarm = st.alarm;
    if (frame_done && !is_read && addr == icc_pkg::ADDR_ALARM)
      next_st.alarm = st.alarm & wdata[5:0];
    if (st.cfg[icc_pkg::BIT_AUTOCLEAR] && good
        && st.good_cnt == 6'(icc_pkg::GOOD_SAMPLES - 1))
      next_st.alarm = next_st.alarm & ~icc_pkg::ALARM_IFACE_MASK;
    next_st.alarm = next_st.alarm | alarm_set;

    // Configuration write, reserved bits forced to zero
    if (frame_done && !is_read && addr == icc_pkg::ADDR_CONFIG)
      next_st.cfg = wdata & icc_pkg::CONFIG_WRITABLE;

    // Collision shutdown follows the sticky collision alarm while enabled and neither mask is set
    next_st.shutdown = collision_shutdown_enable && !collision_alarm_masked
      && !output_gone_masked && st.alarm[icc_pkg::ALM_COLLISION];
    next_st.out_en = st.txen_sy[1] && sif_tx_enable && !st.shutdown
      && !st.cfg[icc_pkg::BIT_IOTEST];

    // Channel mode and per-channel inversion
    dual = !st.cfg[icc_pkg::BIT_QUAD] && channel_pairing_register == icc_pkg::PAIRING_DUAL;
    next_st.active = dual ? 4'h6 : 4'hF;
    next_st.a_out = dual ? '0 : (st.cfg[icc_pkg::BIT_INVERT_A] ? ~ch_a_in : ch_a_in);
    next_st.b_out = st.cfg[icc_pkg::BIT_INVERT_A - 1] ? ~ch_b_in : ch_b_in;
    next_st.c_out = st.cfg[icc_pkg::BIT_INVERT_A - 2] ? ~ch_c_in : ch_c_in;
    next_st.d_out = dual ? '0 : (st.cfg[icc_pkg::BIT_INVERT_A - 3] ? ~ch_d_in : ch_d_in);
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.clk_sy <= 2'h0;
      st.en_sy <= 2'h3;
      st.cfg <= icc_pkg::CONFIG_RESET;
      st.active <= 4'hF;
    end
    else
      st <= next_st;
  end

  // Outputs straight from the state register
  assign sif_data_out = st.sdo;
  assign sif_data_oe = st.sdo_oe;
  assign ch_a_out = st.a_out;
  assign ch_b_out = st.b_out;
  assign ch_c_out = st.c_out;
  assign ch_d_out = st.d_out;
  assign channel_active = st.active;
  assign outputs_enabled = st.out_en;
  assign alarms = st.alarm;
  assign config_value = st.cfg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_good_sample;
    sample_valid && good;
  endsequence
  sequence s_autoclear_hit;
    s_good_sample ##0 (st.cfg[12] && st.good_cnt == 6'd63);
  endsequence

  a_iotest_mutes: assert property (st.cfg[15] |=> !outputs_enabled)
    else $error("outputs on during pattern test");
  a_word_parity: assert property (sample_valid && st.cfg[10]
    && ((^{sample_data, parity_input_pair}) != st.cfg[11]) |=> alarms[0])
    else $error("word parity error not flagged");
  a_frame_parity: assert property (sample_valid && st.cfg[9]
    && ((^{sample_data, frame_in}) != st.cfg[11]) |=> alarms[1])
    else $error("frame parity error not flagged");
  a_autoclear_run: assert property (s_autoclear_hit |=> alarms[2:0] == 3'h0)
    else $error("alarms not cleared after 64 good samples");
  a_alarm_holds: assert property (!st.cfg[12] && alarms[0] && !frame_done
    |=> alarms[0])
    else $error("alarm dropped without software clear");
  a_gap_two_alarm: assert property (fifo_gap_two && st.cfg[3] |=> alarms[3])
    else $error("gap-two alarm missing");
  a_gap_one_off: assert property (fifo_gap_one && !st.cfg[2] && !alarms[4]
    |=> !alarms[4])
    else $error("gap-one alarm while disabled");
  a_collision_alarm: assert property (fifo_collision && st.cfg[1] |=> alarms[5])
    else $error("collision alarm missing");
  a_collision_shutdown: assert property (alarms[5] && collision_shutdown_enable
    && !collision_alarm_masked && !output_gone_masked |=> ##1 !outputs_enabled)
    else $error("collision shutdown missing");
  a_invert_b: assert property (1'b1 |=> ch_b_out == ($past(st.cfg[6])
    ? ~$past(ch_b_in) : $past(ch_b_in)))
    else $error("channel B inversion wrong");
  a_dual_mode: assert property (!st.cfg[8] && channel_pairing_register == 2'h3
    |=> channel_active == 4'h6 && ch_a_out == '0)
    else $error("dual channel mode not applied");
  a_reserved_zero: assert property (config_value[14:13] == 2'h0
    && config_value[0] == 1'b0)
    else $error("reserved bits set");
endmodule

/* File: logic/icc_pkg.sv */
// Constants for the input-check and channel configuration register block.
// Assumes a 20 MHz system clock and a 24-bit serial configuration frame.
package icc_pkg;
  // Register map
  localparam logic [6:0] ADDR_CONFIG = 7'h01;
  localparam logic [6:0] ADDR_ALARM = 7'h05;
  localparam logic [15:0] CONFIG_RESET = 16'h050E;
  localparam logic [15:0] CONFIG_WRITABLE = 16'h9FFE;
  // Configuration field positions
  localparam int BIT_IOTEST = 15;
  localparam int BIT_AUTOCLEAR = 12;
  localparam int BIT_ODD_PARITY = 11;
  localparam int BIT_WORD_PARITY = 10;
  localparam int BIT_FRAME_PARITY = 9;
  localparam int BIT_QUAD = 8;
  localparam int BIT_INVERT_A = 7;
  localparam int BIT_GAP_TWO = 3;
  localparam int BIT_GAP_ONE = 2;
  localparam int BIT_COLLISION = 1;
  // Alarm register field positions
  localparam int ALM_WORD_PARITY = 0;
  localparam int ALM_FRAME_PARITY = 1;
  localparam int ALM_PATTERN = 2;
  localparam int ALM_GAP_TWO = 3;
  localparam int ALM_GAP_ONE = 4;
  localparam int ALM_COLLISION = 5;
  localparam int ALARM_WIDTH = 6;
  localparam logic [5:0] ALARM_IFACE_MASK = 6'h07;
  // Serial frame layout
  localparam int SIF_FRAME_BITS = 24;
  localparam int SIF_HEADER_BITS = 8;
  localparam int SIF_RW_BIT = 23;
  // Good samples before automatic alarm clear
  localparam int GOOD_SAMPLES = 64;
  localparam logic [1:0] PAIRING_DUAL = 2'h3;
endpackage

/* File: testbench/icc_config_reg_tb.sv */
// Self-checking bench for the input-check and channel configuration block.
// Assumes the serial pins are driven here, the data source by the model.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module icc_config_reg_tb;
  logic clk = 1'b0;
  logic arst_n, sck, sen_n, sdi, sdo, soe, txp, txs, shut, cmask, omask, sv, par, frm, oen;
  logic [1:0] pair;
  logic [2:0] ff;
  logic [3:0] act;
  logic [5:0] alm;
  logic [15:0] chv, rv, sd, a_o, b_o, c_o, d_o, cfg;
  // Even word, odd word and framing-line parity settings
  logic [15:0] pcfg [3] = '{16'h050E, 16'h0D0E, 16'h030E};
  int error_cnt = 0;
  int n_checks = 0;

  // 50 ns clock
  always #25 clk = ~clk;

  icc_config_reg uut (.clk(clk), .arst_n(arst_n), .sif_clk(sck), .sif_enable_n(sen_n),
    .sif_data_in(sdi), .sif_data_out(sdo), .sif_data_oe(soe), .sample_valid(sv),
    .sample_data(sd), .parity_input_pair(par), .frame_in(frm), .fifo_gap_two(ff[2]),
    .fifo_gap_one(ff[1]), .fifo_collision(ff[0]), .channel_pairing_register(pair),
    .collision_shutdown_enable(shut), .collision_alarm_masked(cmask),
    .output_gone_masked(omask), .tx_enable_pin(txp), .sif_tx_enable(txs),
    .ch_a_in(chv), .ch_b_in(chv ^ 16'h00FF), .ch_c_in(chv ^ 16'h0F0F),
    .ch_d_in(chv ^ 16'h3333), .ch_a_out(a_o), .ch_b_out(b_o), .ch_c_out(c_o),
    .ch_d_out(d_o), .channel_active(act), .outputs_enabled(oen), .alarms(alm),
    .config_value(cfg));

  icc_source_model src (.clk(clk), .sample_valid(sv), .sample_data(sd),
    .parity_input_pair(par), .frame_in(frm));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One 24-bit frame; phases of 6 clocks outlast the pin synchronisers
  task automatic sif(input logic rd, input logic [6:0] a, input logic [15:0] wd);
    logic [23:0] f;
    f = {rd, a, wd};
    sen_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi = f[i];
      tick(6);
      if (i < 16)
        rv[i] = sdo;
      if (rd && i == 15)
        `CHK("read enable", 1'b1, soe)
      sck = 1'b1;
      tick(6);
      sck = 1'b0;
    end
    tick(2);
    sen_n = 1'b1;
    tick(8);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    sif(1'b0, a, d);
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [15:0] e, input string nm);
    sif(1'b1, a, 16'h0000);
    `CHK(nm, e, rv)
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    {arst_n, sck, sdi, shut, cmask, omask, ff, pair} = '0;
    {sen_n, txp, txs} = 3'h7;
    chv = 16'h1234;
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    tick(4);
    `CHK("cfg reset", 16'h050E, cfg)
    `CHK("quad", 4'hF, act)
    `CHK("out on", 1'b1, oen)
    rdchk(7'h01, 16'h050E, "cfg read");
    done("reset");
    wr(7'h01, 16'hFFFF);
    rdchk(7'h01, 16'h9FFE, "reserved");
    wr(7'h02, 16'h0000);
    rdchk(7'h01, 16'h9FFE, "other addr");
    rdchk(7'h02, 16'h0000, "unmapped");
    `CHK("test off", 1'b0, oen)
    src.send(4, 16'h0000, 1'b1, 1'b0, 1'b0);
    tick(2);
    `CHK("pattern", 1'b1, alm[2])
    `CHK("inv a", ~chv, a_o)
    `CHK("inv d", ~(chv ^ 16'h3333), d_o)
    wr(7'h01, 16'h0550);
    `CHK("keep a", chv, a_o)
    `CHK("inv b", ~(chv ^ 16'h00FF), b_o)
    `CHK("keep c", chv ^ 16'h0F0F, c_o)
    pair = 2'h3;
    wr(7'h01, 16'h0400);
    `CHK("dual", 4'h6, act)
    `CHK("dual a", 16'h0000, a_o)
    `CHK("dual d", 16'h0000, d_o)
    done("fields");
    // Even word, odd word and framing-line parity in turn
    foreach (pcfg[k])
    begin
      wr(7'h01, pcfg[k]);
      wr(7'h05, 16'h0000);
      src.send(8, 16'h00A5, cfg[11], 1'b0, cfg[9]);
      tick(2);
      `CHK("good par", 1'b0, alm[cfg[9]])
      src.send(1, 16'h00A5, cfg[11], 1'b1, cfg[9]);
      tick(2);
      `CHK("bad par", 1'b1, alm[cfg[9]])
    end
    done("parity");
    wr(7'h01, 16'h050E);
    wr(7'h05, 16'h0000);
    src.send(1, 16'h0011, 1'b0, 1'b1, 1'b0);
    src.send(64, 16'h0100, 1'b0, 1'b0, 1'b0);
    tick(2);
    `CHK("no autoclr", 1'b1, alm[0])
    wr(7'h01, 16'h150E);
    src.send(64, 16'h0200, 1'b0, 1'b0, 1'b0);
    tick(2);
    `CHK("autoclr", 1'b0, alm[0])
    done("autoclear");
    shut = 1'b1;
    // Each pointer flag off then on; collision last for shutdown
    for (int j = 2; j >= 0; j--)
    begin
      wr(7'h01, 16'h0500);
      wr(7'h05, 16'h0000);
      ff[j] = 1'b1;
      tick(2);
      `CHK("fifo off", 1'b0, alm[5-j])
      ff[j] = 1'b0;
      wr(7'h01, 16'h0500 | (16'h0002 << j));
      ff[j] = 1'b1;
      tick(2);
      `CHK("fifo on", 1'b1, alm[5-j])
      ff[j] = 1'b0;
    end
    tick(2);
    `CHK("shutdown", 1'b0, oen)
    done("fifo");
    end_of_test();
  end
endmodule

/* File: testbench/icc_source_model.sv */
// Data source model driving the checked parallel input bus.
// Assumes one caller at a time and the same clock as the design.
`timescale 1ns/1ps
module icc_source_model (
  // Clock
  input wire logic clk,
  // Checked input bus
  output logic sample_valid,
  output logic [15:0] sample_data,
  output logic parity_input_pair,
  output logic frame_in
);
  // Idle bus at time zero
  initial
  begin
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    parity_input_pair = 1'b0;
    frame_in = 1'b0;
  end

  // Words d+i; bad flips parity, on_frame moves it to the framing line
  task automatic send(input int n, input logic [15:0] d, input logic odd,
                      input logic bad, input logic on_frame);
    logic p;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      #1;
      p = (^(d + i[15:0])) ^ odd ^ bad;
      sample_valid = 1'b1;
      sample_data = d + i[15:0];
      parity_input_pair = on_frame ? ~p : p;
      frame_in = on_frame ? p : 1'b0;
    end
    @(posedge clk);
    #1;
    // Released lines show no stale word
    sample_valid = 1'b0;
    sample_data = ~sample_data;
    parity_input_pair = ~parity_input_pair;
    frame_in = 1'b0;
  endtask
endmodule
